/* File: rtl/tlic_pkg.sv */
// Package for the two-level interrupt controller: sizes, vector layout, types.
// Assumes one system clock and a core that reports instruction boundaries.
//
// Overview of operation
// - Many sources, each given low or high priority by a priority bit.
// - A source's valid condition sets its pending flag to one.
// - Pending flags set on condition even while the source is disabled.
// - Enabled source with pending flag raises a request to the core.
// - Core finishes current instruction, then long-calls the source's fixed vector.
// - Return instruction resumes at the instruction that would have run next.
// - Disabled source's flag is ignored; no request, program runs on.
// - Per-source enables count only while global enable, bit 7, is one.
// - Global enable zero blocks every source regardless of per-source enables.
// - Designated sources have their flag cleared automatically on vectoring.
// - Flag still set after return re-requests; entry after two more instructions.
// - Software writing one to a flag requests exactly like a hardware event.
package tlic_pkg;

  localparam int          NUM_SRC       = 16;
  localparam int          SRC_W         = 4;
  localparam int          GLOBAL_EN_BIT = 7;
  localparam logic [15:0] VEC_BASE      = 16'h0003;
  localparam logic [15:0] VEC_STRIDE    = 16'h0008;
  localparam logic [15:0] PEND_RESET    = 16'h0000;
  localparam logic [15:0] AUTO_CLR_DEF  = 16'h000f;

  // Service state of the core as seen by the controller
  typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} tlic_lvl_e;

  // Vector request toward the core
  typedef struct packed {
    logic             valid;
    logic             high;
    logic [SRC_W-1:0] src;
    logic [15:0]      addr;
  } tlic_req_s;

endpackage

/* File: rtl/tlic_ctrl.sv */
// Two-level interrupt controller: pending flags, enables, arbitration, nesting.
// Assumes the core pulses instrDone at instruction ends and vectorTaken when
// it performs the long call, and retiDone when a return instruction ends.
`timescale 1ns/1ps
module tlic_ctrl
  import tlic_pkg::*;
#(
  parameter int          NSRC     = NUM_SRC,
  parameter logic [15:0] AUTO_CLR = AUTO_CLR_DEF
) (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rstn,
  // Source events and software access to flags
  input  wire logic [NSRC-1:0] srcEvent,
  input  wire logic [NSRC-1:0] swSet,
  input  wire logic [NSRC-1:0] swClear,
  // Enable and priority configuration
  input  wire logic [7:0]      interrupt_enable_reg,
  input  wire logic [7:0]      extended_enable_reg_one,
  input  wire logic [NSRC-1:0] prioHigh,
  // Core handshake
  input  wire logic            instrDone,
  input  wire logic            vectorTaken,
  input  wire logic            retiDone,
  // Outputs
  output tlic_req_s            req,
  output logic [NSRC-1:0]      pending,
  output tlic_lvl_e            level
);

  ////////////////////////////////////////////////////////////////////////////
  // Enables: bit 7 of the base register gates everything
  logic              global_interrupt_enable;
  logic [NSRC-1:0]   srcEnable;
  logic [NSRC-1:0]   active;
  logic [NSRC-1:0]   activeHigh;
  logic [NSRC-1:0]   activeLow;
  assign global_interrupt_enable = interrupt_enable_reg[GLOBAL_EN_BIT];
  // Base register gives the low sources, the extended register the next eight; top has none
  assign srcEnable  = NSRC'({1'b0, extended_enable_reg_one,
                             interrupt_enable_reg[GLOBAL_EN_BIT-1:0]});
  assign active     = global_interrupt_enable ? (pending & srcEnable) : '0;
  assign activeHigh = active & prioHigh;
  assign activeLow  = active & ~prioHigh;

  // Lowest index wins within a level
  function automatic logic [SRC_W-1:0] first_set(input logic [NSRC-1:0] v);
    first_set = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = SRC_W'(i);
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration against the level in service; high preempts low only
  logic              canHigh;
  logic              canLow;
  logic              holdOff;
  logic [SRC_W-1:0]  pick;
  logic              gapHold;
  // A return blocks arbitration in its own cycle too, so two instructions always run before the next entry
  assign gapHold = holdOff || retiDone;
  assign canHigh = (|activeHigh) && (level != ST_HIGH);
  assign canLow  = (|activeLow) && (level == ST_IDLE);
  assign pick    = canHigh ? first_set(activeHigh) : first_set(activeLow);

  // Request is qualified at an instruction end, never mid-instruction
  tlic_req_s next_req;
  always_comb begin
    next_req       = req;
    if (vectorTaken) begin
      next_req.valid = 1'b0;
    end
    if (!req.valid && instrDone && !gapHold && (canHigh || canLow)) begin
      next_req.valid = 1'b1;
      next_req.high  = canHigh;
      next_req.src   = pick;
      next_req.addr  = VEC_BASE + 16'(pick) * VEC_STRIDE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      req <= '0;
    end else begin
      req <= next_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending flags: set wins over clear, auto clear on vectoring
  logic [NSRC-1:0] autoClr;
  logic [NSRC-1:0] next_pending;
  assign autoClr = (vectorTaken && req.valid) ?
                   (AUTO_CLR[NSRC-1:0] & (NSRC'(1) << req.src)) : '0;
  assign next_pending = (pending & ~swClear & ~autoClr) | srcEvent | swSet;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pending <= PEND_RESET[NSRC-1:0];
    end else begin
      pending <= next_pending;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Nesting level and the two-instruction gap after a return
  tlic_lvl_e savedLvl;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      level    <= ST_IDLE;
      savedLvl <= ST_IDLE;
      holdOff  <= 1'b0;
    end else begin
      if (vectorTaken && req.valid) begin
        savedLvl <= level;
        level    <= req.high ? ST_HIGH : ST_LOW;
      end else if (retiDone) begin
        level    <= (level == ST_HIGH) ? savedLvl : ST_IDLE;
        savedLvl <= ST_IDLE;
      end
      if (retiDone) begin
        holdOff <= 1'b1;
      end else if (instrDone) begin
        holdOff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_flag_sets;
    @(posedge clk) disable iff (!rstn)
      (|srcEvent) |=> ((pending & $past(srcEvent)) == $past(srcEvent));
  endproperty
  a_flag_sets: assert property (p_flag_sets) else $error("event lost");

  property p_flag_masked;
    @(posedge clk) disable iff (!rstn)
      (|(srcEvent & ~srcEnable))
      |=> ((pending & $past(srcEvent & ~srcEnable)) == $past(srcEvent & ~srcEnable));
  endproperty
  a_flag_masked: assert property (p_flag_masked) else $error("masked event lost");

  property p_global_off;
    @(posedge clk) disable iff (!rstn)
      (!global_interrupt_enable && !req.valid) |=> !req.valid;
  endproperty
  a_global_off: assert property (p_global_off) else $error("request while disabled");

  property p_req_at_boundary;
    @(posedge clk) disable iff (!rstn) $rose(req.valid) |-> $past(instrDone);
  endproperty
  a_req_at_boundary: assert property (p_req_at_boundary) else $error("mid-instr");

  property p_req_enabled;
    @(posedge clk) disable iff (!rstn)
      $rose(req.valid) |-> (|($past(active) & (NSRC'(1) << req.src)));
  endproperty
  a_req_enabled: assert property (p_req_enabled) else $error("disabled source");

  property p_sw_set;
    @(posedge clk) disable iff (!rstn)
      (|swSet) |=> ((pending & $past(swSet)) == $past(swSet));
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("soft set lost");

  property p_hold;
    @(posedge clk) disable iff (!rstn)
      (pending[5] && !swClear[5] && !(vectorTaken && req.valid)) |=> pending[5];
  endproperty
  a_hold: assert property (p_hold) else $error("flag dropped");

  property p_auto_clr;
    @(posedge clk) disable iff (!rstn)
      (vectorTaken && req.valid && AUTO_CLR[req.src] && !srcEvent[req.src] && !swSet[req.src])
      |=> !pending[$past(req.src)];
  endproperty
  a_auto_clr: assert property (p_auto_clr) else $error("no auto clear");

  property p_return_from_interrupt_instruction_gap;
    @(posedge clk) disable iff (!rstn) (retiDone && !req.valid) |=> !req.valid;
  endproperty
  a_return_from_interrupt_instruction_gap: assert property (p_return_from_interrupt_instruction_gap) else $error("no gap after return");

  property p_high_level;
    @(posedge clk) disable iff (!rstn)
      (vectorTaken && req.valid && req.high) |=> (level == ST_HIGH);
  endproperty
  a_high_level: assert property (p_high_level) else $error("level wrong");

  property p_req_stands;
    @(posedge clk) disable iff (!rstn)
      (req.valid && !vectorTaken) |=> (req.valid && $stable(req.src) && $stable(req.addr));
  endproperty
  a_req_stands: assert property (p_req_stands) else $error("request withdrawn");

  property p_low_only_idle;
    @(posedge clk) disable iff (!rstn)
      ($rose(req.valid) && !req.high) |-> ($past(level) == ST_IDLE);
  endproperty
  a_low_only_idle: assert property (p_low_only_idle) else $error("low while busy");

  property p_high_not_nested;
    @(posedge clk) disable iff (!rstn)
      $rose(req.valid) |-> ($past(level) != ST_HIGH);
  endproperty
  a_high_not_nested: assert property (p_high_not_nested) else $error("high nested");

  property p_high_first;
    @(posedge clk) disable iff (!rstn)
      ($rose(req.valid) && !req.high) |-> ($past(activeHigh) == '0);
  endproperty
  a_high_first: assert property (p_high_first) else $error("low beat high");

  property p_ret_level;
    @(posedge clk) disable iff (!rstn)
      (retiDone && !(vectorTaken && req.valid) && level == ST_LOW) |=> (level == ST_IDLE);
  endproperty
  a_ret_level: assert property (p_ret_level) else $error("low return wrong");

  property p_ret_nested;
    @(posedge clk) disable iff (!rstn)
      (retiDone && !(vectorTaken && req.valid) && level == ST_HIGH)
      |=> (level == $past(savedLvl));
  endproperty
  a_ret_nested: assert property (p_ret_nested) else $error("nested return wrong");

endmodule

/* File: dv/tlic_core_model.sv */
// Core model: one-cycle instructions, prompt long call, return on command.
// Assumes the controller holds req.valid until it sees vectorTaken.
`timescale 1ns/1ps
module tlic_core_model
  import tlic_pkg::*;
(
  // Clock, reset, request
  input  wire logic clk,
  input  wire logic rstn,
  input  tlic_req_s req,
  input  wire logic retCmd,
  // Core handshake
  output logic      instrDone,
  output logic      vectorTaken,
  output logic      retiDone
);
  ////////////////////////////////////////////////////////////////////////////
  // One pulse per request, so a held request is never taken twice
  always_ff @(posedge clk) begin
    instrDone   <= rstn;
    vectorTaken <= rstn & req.valid & ~vectorTaken;
    retiDone    <= rstn & retCmd;
  end
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the interrupt controller.
// Assumes the core model answers every request promptly.
`timescale 1ns/1ps
module testbench
  import tlic_pkg::*;
;
  logic        clk = 0, rstn = 0, retCmd = 0;
  logic        instrDone, vectorTaken, retiDone;
  logic [15:0] srcEvent = 0, swSet = 0, swClear = 0, prioHigh = 0;
  logic [7:0]  ieReg = 0, eieReg = 0;
  tlic_req_s   req;
  logic [15:0] pending;
  tlic_lvl_e   level;
  int          bad_count = 0, num_checks = 0;

  always #2.5 clk = ~clk;

  tlic_ctrl tlic_ctrl_i (.clk(clk), .rstn(rstn), .srcEvent(srcEvent), .swSet(swSet),
    .swClear(swClear), .interrupt_enable_reg(ieReg), .extended_enable_reg_one(eieReg),
    .prioHigh(prioHigh), .instrDone(instrDone), .vectorTaken(vectorTaken),
    .retiDone(retiDone), .req(req), .pending(pending), .level(level));
  tlic_core_model tlic_core_model_i (.clk(clk), .rstn(rstn), .req(req), .retCmd(retCmd),
    .instrDone(instrDone), .vectorTaken(vectorTaken), .retiDone(retiDone));

  ////////////////////////////////////////////////////////////////////////////
  // Compare and verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Stimulus tasks; inputs change only at rising edges
  task automatic raise(input logic [15:0] ev, input logic [15:0] st);
    @(posedge clk) begin srcEvent <= ev; swSet <= st; end
    @(posedge clk) begin srcEvent <= 0; swSet <= 0; end
  endtask
  task automatic no_req();
    repeat (8) begin @(negedge clk); chk(req.valid, 0); end
  endtask
  // Software clear of pending flags inside a service routine
  task automatic clear_flag(input logic [15:0] m);
    @(posedge clk) swClear <= m;
    @(posedge clk) swClear <= 0;
  endtask
  task automatic ret(input tlic_lvl_e lv = ST_IDLE);
    @(posedge clk) retCmd <= 1;
    @(posedge clk) retCmd <= 0;
    repeat (3) @(negedge clk);
    chk(level, lv);
  endtask
  // Bounded wait for a request, then check its vector and the new level
  task automatic wait_vec(input int src, input logic hi);
    int n;
    n = 0;
    @(negedge clk);
    while (req.valid !== 1'b1 && n < 20) begin @(negedge clk); n++; end
    if (req.valid !== 1'b1) begin bad_count++; close_out(); end
    chk(req.src, src);
    chk(req.high, hi);
    chk(req.addr, VEC_BASE + VEC_STRIDE*src);
    repeat (2) @(negedge clk);
    chk(level, hi ? ST_HIGH : ST_LOW);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1;
    @(negedge clk);
    chk({req.valid, pending}, 0);
    raise(16'h0010, 0);
    @(negedge clk);
    chk(pending, 16'h0010);
    no_req();
    @(posedge clk) ieReg <= 8'h10;
    no_req();
    @(posedge clk) ieReg <= 8'h90;
    wait_vec(4, 0);
    chk(pending, 16'h0010);
    ret();
    wait_vec(4, 0);
    clear_flag(16'h0010);
    ret();
    no_req();
    @(posedge clk) ieReg <= 8'h82;
    raise(0, 16'h0002);
    wait_vec(1, 0);
    chk(pending[1], 0);
    ret();
    @(posedge clk) begin ieReg <= 8'h20; eieReg <= 8'h02; prioHigh <= 16'h0100; end
    raise(16'h0120, 0);
    @(posedge clk) ieReg <= 8'ha0;
    wait_vec(8, 1);
    clear_flag(16'h0100);
    ret();
    wait_vec(5, 0);
    // High source preempts the low routine, then returns to it
    raise(16'h0100, 0);
    wait_vec(8, 1);
    clear_flag(16'h0100);
    ret(ST_LOW);
    clear_flag(16'h0020);
    ret();
    no_req();
    close_out();
  end
endmodule
